/* rtl/pmx_map.svh */
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
`define PMX_ADR_MSB 15
`define PMX_ADR_LSB 2
`define PMX_IDX_BUS_SEL 14'h1C00
`define PMX_IDX_STATUS 14'h1C01
`define PMX_IDX_SLEW 14'h1C16
`define PMX_IDX_INH1 14'h1C17
`define PMX_IDX_INH2 14'h1C18
`define PMX_IDX_INH3 14'h1C19
`define PMX_BUS_SEL_RST 16'h0000
`define PMX_BUS_SEL_MASK 16'h7C3F
`define PMX_SLEW_RST 16'h0000
`define PMX_SLEW_MASK 16'h0003
`define PMX_INH_RST 16'h0000
`define PMX_INH3_MASK 16'hFFFC
`define PMX_PP_MSB 14
`define PMX_PP_LSB 12
`define PMX_SP1_MSB 11
`define PMX_SP1_LSB 10
`define PMX_ADDR_MSB 5
`define PMX_SLEW_CLOCK_OUT_PIN 0
`define PMX_SLEW_EXTERNAL_MEMORY_INTERFACE 1
`define PMX_SP1_PULL0 6
`define PMX_ST_CORE_OFF 0
`define PMX_ST_PP_RSVD 1
`define PMX_ST_SP1_RSVD 2
`define PMX_PP_PINS 22
`define PMX_SP1_PINS 6
`define PMX_ADDR_PINS 6
`define PMX_PP_D2 3
`define PMX_PP_D8 9
`define PMX_PP_D12 13
`define PMX_PP_CS0 17
`define PMX_SP1_D2 4
`endif

/* rtl/pmx_pkg.sv */
package pmx_pkg;
  typedef enum logic [2:0] {
    PMX_FN_LCD, PMX_FN_SPI, PMX_FN_GPIO, PMX_FN_UART,
    PMX_FN_AUD1, PMX_FN_AUD2, PMX_FN_AUD3, PMX_FN_CARD1
  } pmx_func_t;
  typedef enum logic [2:0] {
    PMX_PP_M0, PMX_PP_M1, PMX_PP_M2, PMX_PP_M3,
    PMX_PP_M4, PMX_PP_M5, PMX_PP_M6, PMX_PP_RSVD
  } pmx_pp_mode_t;
  typedef enum logic [1:0] {
    PMX_SP1_M0, PMX_SP1_M1, PMX_SP1_M2, PMX_SP1_RSVD
  } pmx_sp1_mode_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } pmx_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pmx_wb_rsp_t;
  typedef struct packed {
    logic [15:0] pull_en_one;
    logic [15:0] pull_en_two;
    logic [15:0] pull_en_three;
    logic bus_hold_en;
    logic clock_out_pin_slow;
    logic external_memory_interface_slow;
  } pmx_pad_t;
endpackage

/* rtl/pmx_top.sv */
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "pmx_map.svh"

// Summary of operation
// R1: Each internal pull except the test-reset one has its own inhibit bit.
// R2: Software disables a pull when something external already sets the level.
// R3: With core supply off, all pulls are forced off and bus-holders enabled.
// R4: Slew register picks fast or slow edges for clock-out and memory pins.
// R5: One bus select register holds every pin mux control.
// R6: Software resets affected peripherals after changing any pin mux setting.
// R7: Three-bit parallel-port field decodes modes 0 to 6.
// R8: Mode 0 all LCD; mode 2 routes LCD data 8-15 to GPIO.
// R9: Mode 1 gives SPI, GPIO 12-17, audio port two and UART.
// R10: Mode 3 keeps LCD low data; SPI on data 8-11, audio three above.
// R11: Modes 4 and 5 carry UART high; audio two or SPI on data 8-11.
// R12: Mode 6 like mode 1 low, audio two and audio three high.
// R13: Third inhibit register switches pull-downs of LCD data 2 to 15 only.
// R14: Two-bit serial-port-1 field decodes modes 0, 1 and 2.
// R15: Mode 0 memory card one; mode 1 audio port one plus GPIO 10-11.
// R16: Mode 2 routes all six card pins to GPIO 6 to 11.
// R17: Each of the six card pins has its own pull-down inhibit bit.
// R18: Reserved mode codes fall back to the mode 0 routing.
// R19: Address mode bit 0 selects memory address, 1 selects paired GPIO.
module pmx_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire pmx_pkg::pmx_wb_req_t i_wb,
  input wire logic i_core_supply_off,
  output pmx_pkg::pmx_wb_rsp_t o_wb,
  output pmx_pkg::pmx_pad_t o_pad,
  output pmx_pkg::pmx_func_t [`PMX_PP_PINS-1:0] o_pp_func,
  output pmx_pkg::pmx_func_t [`PMX_SP1_PINS-1:0] o_sp1_func,
  output logic [`PMX_ADDR_PINS-1:0] o_addr_gpio
);

  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [15:0] bus_sel_ff;
  logic [15:0] slew_ff;
  logic [15:0] inh1_ff;
  logic [15:0] inh2_ff;
  logic [15:0] inh3_ff;
  logic core_off_meta_ff;
  logic core_off_ff;
  logic [13:0] idx;
  logic req;
  logic wr;
  pmx_pkg::pmx_pp_mode_t pp_mode;
  pmx_pkg::pmx_sp1_mode_t sp1_mode;

  function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    lane_wr = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic pmx_pkg::pmx_func_t pp_decode(input pmx_pkg::pmx_pp_mode_t m,
                                                   input int pin);
    pmx_pkg::pmx_func_t f;
    f = pmx_pkg::PMX_FN_LCD;
    if (pin < `PMX_PP_D2 || pin >= `PMX_PP_CS0) begin
      if (m == pmx_pkg::PMX_PP_M1 || m == pmx_pkg::PMX_PP_M6) begin // [R9] [R12]
        f = pmx_pkg::PMX_FN_SPI;
      end
    end else if (pin < `PMX_PP_D8) begin
      if (m == pmx_pkg::PMX_PP_M1 || m == pmx_pkg::PMX_PP_M6) begin // [R9] [R12]
        f = pmx_pkg::PMX_FN_GPIO;
      end
    end else if (pin < `PMX_PP_D12) begin
      case (m)
        pmx_pkg::PMX_PP_M1, pmx_pkg::PMX_PP_M4, pmx_pkg::PMX_PP_M6: begin // [R11] [R12]
          f = pmx_pkg::PMX_FN_AUD2;
        end
        pmx_pkg::PMX_PP_M2: begin // [R8]
          f = pmx_pkg::PMX_FN_GPIO;
        end
        pmx_pkg::PMX_PP_M3, pmx_pkg::PMX_PP_M5: begin // [R10] [R11]
          f = pmx_pkg::PMX_FN_SPI;
        end
        default: begin // [R18]
          f = pmx_pkg::PMX_FN_LCD;
        end
      endcase
    end else begin
      case (m)
        pmx_pkg::PMX_PP_M1, pmx_pkg::PMX_PP_M4, pmx_pkg::PMX_PP_M5: begin // [R9] [R11]
          f = pmx_pkg::PMX_FN_UART;
        end
        pmx_pkg::PMX_PP_M2: begin // [R8]
          f = pmx_pkg::PMX_FN_GPIO;
        end
        pmx_pkg::PMX_PP_M3, pmx_pkg::PMX_PP_M6: begin // [R10] [R12]
          f = pmx_pkg::PMX_FN_AUD3;
        end
        default: begin // [R18]
          f = pmx_pkg::PMX_FN_LCD;
        end
      endcase
    end
    return f;
  endfunction

  function automatic pmx_pkg::pmx_func_t sp1_decode(input pmx_pkg::pmx_sp1_mode_t m,
                                                    input int pin);
    pmx_pkg::pmx_func_t f;
    case (m)
      pmx_pkg::PMX_SP1_M1: begin // [R15]
        f = (pin < `PMX_SP1_D2) ? pmx_pkg::PMX_FN_AUD1 : pmx_pkg::PMX_FN_GPIO;
      end
      pmx_pkg::PMX_SP1_M2: begin // [R16]
        f = pmx_pkg::PMX_FN_GPIO;
      end
      default: begin // [R15] [R18]
        f = pmx_pkg::PMX_FN_CARD1;
      end
    endcase
    return f;
  endfunction

  assign idx = i_wb.adr[`PMX_ADR_MSB:`PMX_ADR_LSB];
  assign req = i_wb.cyc & i_wb.stb;
  // Writes land on the edge the master samples ack, never earlier
  assign wr = req & i_wb.we & ack_ff;
  assign pp_mode = pmx_pkg::pmx_pp_mode_t'(bus_sel_ff[`PMX_PP_MSB:`PMX_PP_LSB]); // [R7]
  assign sp1_mode = pmx_pkg::pmx_sp1_mode_t'(bus_sel_ff[`PMX_SP1_MSB:`PMX_SP1_LSB]); // [R14]

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    nxt_rdat = 32'h0000_0000;
    case (idx)
      `PMX_IDX_BUS_SEL: nxt_rdat[15:0] = bus_sel_ff;
      `PMX_IDX_SLEW: nxt_rdat[15:0] = slew_ff;
      `PMX_IDX_INH1: nxt_rdat[15:0] = inh1_ff;
      `PMX_IDX_INH2: nxt_rdat[15:0] = inh2_ff;
      `PMX_IDX_INH3: nxt_rdat[15:0] = inh3_ff;
      `PMX_IDX_STATUS: begin
        nxt_rdat[`PMX_ST_CORE_OFF] = core_off_ff;
        nxt_rdat[`PMX_ST_PP_RSVD] = (pp_mode == pmx_pkg::PMX_PP_RSVD);
        nxt_rdat[`PMX_ST_SP1_RSVD] = (sp1_mode == pmx_pkg::PMX_SP1_RSVD);
      end
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign o_wb.ack = ack_ff;
  assign o_wb.dat = rdat_ff;

  // Only this register steers any pin function
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus_sel_ff <= `PMX_BUS_SEL_RST;
    end else if (wr && idx == `PMX_IDX_BUS_SEL) begin // [R5]
      bus_sel_ff <= lane_wr(bus_sel_ff, i_wb.dat, i_wb.sel) & `PMX_BUS_SEL_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      slew_ff <= `PMX_SLEW_RST;
    end else if (wr && idx == `PMX_IDX_SLEW) begin // [R4]
      slew_ff <= lane_wr(slew_ff, i_wb.dat, i_wb.sel) & `PMX_SLEW_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      inh1_ff <= `PMX_INH_RST;
      inh2_ff <= `PMX_INH_RST;
      inh3_ff <= `PMX_INH_RST;
    end else if (wr) begin
      if (idx == `PMX_IDX_INH1) begin // [R1] [R17]
        inh1_ff <= lane_wr(inh1_ff, i_wb.dat, i_wb.sel);
      end
      if (idx == `PMX_IDX_INH2) begin // [R1]
        inh2_ff <= lane_wr(inh2_ff, i_wb.dat, i_wb.sel);
      end
      if (idx == `PMX_IDX_INH3) begin // [R13]
        inh3_ff <= lane_wr(inh3_ff, i_wb.dat, i_wb.sel) & `PMX_INH3_MASK;
      end
    end
  end

  // Supply status comes from the power domain, so it is synchronised first
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      core_off_meta_ff <= 1'b0;
      core_off_ff <= 1'b0;
    end else begin
      core_off_meta_ff <= i_core_supply_off;
      core_off_ff <= core_off_meta_ff;
    end
  end

  // Forcing overrides the inhibit contents without disturbing them
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pad <= '0;
    end else begin
      o_pad.pull_en_one <= core_off_ff ? 16'h0000 : ~inh1_ff; // [R1] [R3] [R17]
      o_pad.pull_en_two <= core_off_ff ? 16'h0000 : ~inh2_ff; // [R1] [R3]
      o_pad.pull_en_three <= core_off_ff ? 16'h0000 : (~inh3_ff & `PMX_INH3_MASK); // [R13]
      o_pad.bus_hold_en <= core_off_ff; // [R3]
      o_pad.clock_out_pin_slow <= slew_ff[`PMX_SLEW_CLOCK_OUT_PIN]; // [R4]
      o_pad.external_memory_interface_slow <= slew_ff[`PMX_SLEW_EXTERNAL_MEMORY_INTERFACE]; // [R4]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_addr_gpio <= '0;
    end else begin
      o_addr_gpio <= bus_sel_ff[`PMX_ADDR_MSB:0]; // [R19]
    end
  end

  // Reset leaves every pin at its mode 0 function
  for (genvar p = 0; p < `PMX_PP_PINS; p++) begin : g_pp
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        o_pp_func[p] <= pp_decode(pmx_pkg::PMX_PP_M0, p);
      end else begin
        o_pp_func[p] <= pp_decode(pp_mode, p); // [R7]
      end
    end
  end

  for (genvar s = 0; s < `PMX_SP1_PINS; s++) begin : g_sp1
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        o_sp1_func[s] <= pmx_pkg::PMX_FN_CARD1;
      end else begin
        o_sp1_func[s] <= sp1_decode(sp1_mode, s); // [R14]
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_ack_single;
    o_wb.ack |=> !o_wb.ack;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack held longer than one cycle");

  property p_pull_two;
    !core_off_ff |=> o_pad.pull_en_two == ~$past(inh2_ff);
  endproperty
  a_pull_two: assert property (p_pull_two) // [R1]
    else $error("pull enable does not follow inhibit bits");

  property p_core_off;
    core_off_ff |=> o_pad.bus_hold_en && o_pad.pull_en_one == 16'h0000
      && o_pad.pull_en_two == 16'h0000 && o_pad.pull_en_three == 16'h0000;
  endproperty
  a_core_off: assert property (p_core_off) // [R3]
    else $error("pulls not forced off with core supply down");

  property p_slew;
    wr && idx == `PMX_IDX_SLEW && i_wb.sel[0]
      |=> ##1 o_pad.external_memory_interface_slow == $past(i_wb.dat[`PMX_SLEW_EXTERNAL_MEMORY_INTERFACE], 2);
  endproperty
  a_slew: assert property (p_slew) // [R4]
    else $error("slew select not applied two cycles after write");

  property p_pp_mode1;
    pp_mode == pmx_pkg::PMX_PP_M1 |=> o_pp_func[0] == pmx_pkg::PMX_FN_SPI
      && o_pp_func[3] == pmx_pkg::PMX_FN_GPIO && o_pp_func[9] == pmx_pkg::PMX_FN_AUD2
      && o_pp_func[13] == pmx_pkg::PMX_FN_UART && o_pp_func[20] == pmx_pkg::PMX_FN_SPI;
  endproperty
  a_pp_mode1: assert property (p_pp_mode1) // [R9]
    else $error("parallel port mode 1 routing wrong");

  property p_pp_mode2;
    pp_mode == pmx_pkg::PMX_PP_M2 |=> o_pp_func[8] == pmx_pkg::PMX_FN_LCD
      && o_pp_func[9] == pmx_pkg::PMX_FN_GPIO && o_pp_func[16] == pmx_pkg::PMX_FN_GPIO;
  endproperty
  a_pp_mode2: assert property (p_pp_mode2) // [R8]
    else $error("parallel port mode 2 routing wrong");

  property p_pp_mode3;
    pp_mode == pmx_pkg::PMX_PP_M3 |=> o_pp_func[12] == pmx_pkg::PMX_FN_SPI
      && o_pp_func[13] == pmx_pkg::PMX_FN_AUD3 && o_pp_func[0] == pmx_pkg::PMX_FN_LCD;
  endproperty
  a_pp_mode3: assert property (p_pp_mode3) // [R10]
    else $error("parallel port mode 3 routing wrong");

  property p_pp_mode5;
    pp_mode == pmx_pkg::PMX_PP_M5 |=> o_pp_func[10] == pmx_pkg::PMX_FN_SPI
      && o_pp_func[16] == pmx_pkg::PMX_FN_UART && o_pp_func[17] == pmx_pkg::PMX_FN_LCD;
  endproperty
  a_pp_mode5: assert property (p_pp_mode5) // [R11]
    else $error("parallel port mode 5 routing wrong");

  property p_pp_mode6;
    pp_mode == pmx_pkg::PMX_PP_M6 |=> o_pp_func[11] == pmx_pkg::PMX_FN_AUD2
      && o_pp_func[15] == pmx_pkg::PMX_FN_AUD3 && o_pp_func[7] == pmx_pkg::PMX_FN_GPIO;
  endproperty
  a_pp_mode6: assert property (p_pp_mode6) // [R12]
    else $error("parallel port mode 6 routing wrong");

  property p_pp_rsvd;
    pp_mode == pmx_pkg::PMX_PP_RSVD |=> o_pp_func[9] == pmx_pkg::PMX_FN_LCD
      && o_pp_func[14] == pmx_pkg::PMX_FN_LCD;
  endproperty
  a_pp_rsvd: assert property (p_pp_rsvd) // [R18]
    else $error("reserved parallel port code not at default");

  property p_sp1_mode1;
    sp1_mode == pmx_pkg::PMX_SP1_M1 |=> o_sp1_func[3] == pmx_pkg::PMX_FN_AUD1
      && o_sp1_func[4] == pmx_pkg::PMX_FN_GPIO;
  endproperty
  a_sp1_mode1: assert property (p_sp1_mode1) // [R15]
    else $error("serial port 1 mode 1 routing wrong");

  property p_sp1_mode2;
    sp1_mode == pmx_pkg::PMX_SP1_M2 |=> o_sp1_func[0] == pmx_pkg::PMX_FN_GPIO;
  endproperty
  a_sp1_mode2: assert property (p_sp1_mode2) // [R16]
    else $error("serial port 1 mode 2 routing wrong");

  property p_inh3_low;
    o_pad.pull_en_three[1:0] == 2'b00 && inh3_ff[1:0] == 2'b00;
  endproperty
  a_inh3_low: assert property (p_inh3_low) // [R13]
    else $error("uncontrolled bits of third inhibit register active");

  property p_card_pull;
    !core_off_ff && inh1_ff[`PMX_SP1_PULL0] |=> !o_pad.pull_en_one[`PMX_SP1_PULL0];
  endproperty
  a_card_pull: assert property (p_card_pull) // [R17]
    else $error("card clock pull not inhibited");

  property p_addr_bit;
    wr && idx == `PMX_IDX_BUS_SEL && i_wb.sel[0]
      |=> ##1 o_addr_gpio == $past(i_wb.dat[`PMX_ADDR_MSB:0], 2);
  endproperty
  a_addr_bit: assert property (p_addr_bit) // [R19]
    else $error("address mode bits not applied");

  c_mode1: cover property (pp_mode == pmx_pkg::PMX_PP_M1);
  c_mode6: cover property (pp_mode == pmx_pkg::PMX_PP_M6);
  c_sp1: cover property (sp1_mode == pmx_pkg::PMX_SP1_M1);
  c_core_off: cover property (o_pad.bus_hold_en);
  c_slew_wr: cover property (wr && idx == `PMX_IDX_SLEW);

endmodule

/* bench/pmx_partner.sv */
`timescale 1ns/1ps
module pmx_partner (
  input wire logic i_clk,
  input wire logic i_drop,
  input wire pmx_pkg::pmx_func_t [21:0] i_pp_func,
  output logic o_core_supply_off,
  output logic o_periph_reset
);
  pmx_pkg::pmx_func_t [21:0] seen_ff;
  // Supply drops and returns only when the bench commands it
  always @(posedge i_clk) begin
    o_core_supply_off <= i_drop;
    seen_ff <= i_pp_func;
    // Peripherals on remuxed parallel-port pins take a reset before use
    o_periph_reset <= (seen_ff !== i_pp_func);
  end
endmodule

/* bench/pin_mux_pull_slew_control_bench.sv */
`timescale 1ns/1ps
`include "pmx_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module pin_mux_pull_slew_control_bench;
  localparam logic [23:0] CGRP = {3'h0, 3'h5, 3'h1, 3'h5, 3'h1, 3'h2, 3'h5, 3'h0};
  localparam logic [23:0] DGRP = {3'h0, 3'h6, 3'h3, 3'h3, 3'h6, 3'h2, 3'h3, 3'h0};
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic drop = 1'b0;
  pmx_pkg::pmx_wb_req_t req = '0;
  pmx_pkg::pmx_wb_rsp_t rsp;
  pmx_pkg::pmx_pad_t pad;
  pmx_pkg::pmx_func_t [21:0] ppf;
  pmx_pkg::pmx_func_t [5:0] spf;
  logic [5:0] ag;
  logic core_off;
  logic prst;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int prst_n = 0;
  int prst_base = 0;
  logic [31:0] seed = 32'h0000BFC2;
  logic [15:0] exp_q[$];
  logic [15:0] v, a, c;
  logic [15:0] e;
  logic [13:0] idxs [5] = '{`PMX_IDX_SLEW, `PMX_IDX_INH1, `PMX_IDX_INH2, `PMX_IDX_INH3,
    `PMX_IDX_BUS_SEL};
  logic [15:0] masks [5] = '{16'h0003, 16'hFFFF, 16'hFFFF, 16'hFFFC, 16'h7C3F};

  pmx_top pmx_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_wb(req), .i_core_supply_off(core_off),
    .o_wb(rsp), .o_pad(pad), .o_pp_func(ppf), .o_sp1_func(spf), .o_addr_gpio(ag));
  pmx_partner pmx_partner_i (.i_clk(i_clk), .i_drop(drop), .i_pp_func(ppf),
    .o_core_supply_off(core_off), .o_periph_reset(prst));

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic pmx_pkg::pmx_func_t ppx(int m, int p);
    if (p <= 2 || p >= 17) return (m == 1 || m == 6) ? pmx_pkg::PMX_FN_SPI : pmx_pkg::PMX_FN_LCD;
    if (p <= 8) return (m == 1 || m == 6) ? pmx_pkg::PMX_FN_GPIO : pmx_pkg::PMX_FN_LCD;
    if (p <= 12) return pmx_pkg::pmx_func_t'(CGRP[3*m +: 3]);
    return pmx_pkg::pmx_func_t'(DGRP[3*m +: 3]);
  endfunction

  function automatic pmx_pkg::pmx_func_t spx(int m, int p);
    if (m == 2) return pmx_pkg::PMX_FN_GPIO;
    if (m == 1) return (p < 4) ? pmx_pkg::PMX_FN_AUD1 : pmx_pkg::PMX_FN_GPIO;
    return pmx_pkg::PMX_FN_CARD1;
  endfunction

  task automatic wb(input logic w, input logic [13:0] idx, input logic [15:0] d,
    input logic [3:0] s, input logic [15:0] ex);
    @(posedge i_clk);
    if (!w) exp_q.push_back(ex);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, dat: {16'h0000, d}, sel: s};
    do @(posedge i_clk); while (rsp.ack !== 1'b1);
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d, 4'h3, 16'h0000);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [15:0] ex);
    wb(1'b0, idx, 16'h0000, 4'h3, ex);
  endtask

  task automatic rst(input int n);
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (n) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  // Reads are judged where the answer shows, in issue order
  always @(posedge i_clk) begin
    if (rsp.ack === 1'b1 && req.we === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
      `CHK("read_data", {16'h0000, e}, rsp.dat)
    end
  end

  task automatic final_report();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (prst === 1'b1) prst_n++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    rst(20);
    for (int i = 0; i < 5; i++) rd(idxs[i], 16'h0000);
    `CHK("pull_three", 16'hFFFC, pad.pull_en_three)
    `CHK("pp_func0", pmx_pkg::PMX_FN_LCD, ppf[0])
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) begin
      v = 16'(xs());
      wr(idxs[i], v);
      rd(idxs[i], v & masks[i]);
    end
    wb(1'b1, 14'h1C05, 16'hFFFF, 4'h3, 16'h0000);
    rd(14'h1C05, 16'h0000);
    wb(1'b1, `PMX_IDX_STATUS, 16'hFFFF, 4'h3, 16'h0000);
    $display("test register_access done");
    a = 16'(xs());
    c = 16'(xs());
    // External resistors present, so those pulls go off
    wr(`PMX_IDX_INH1, a);
    wr(`PMX_IDX_INH2, 16'h0000);
    wr(`PMX_IDX_INH3, c);
    wr(`PMX_IDX_SLEW, 16'h0002);
    wb(1'b1, `PMX_IDX_INH2, 16'hFFFF, 4'h1, 16'h0000);
    rd(`PMX_IDX_INH2, 16'h00FF);
    repeat (4) @(posedge i_clk);
    `CHK("pull_one", ~a, pad.pull_en_one)
    `CHK("pull_two", 16'hFF00, pad.pull_en_two)
    `CHK("pull_three", ~c & 16'hFFFC, pad.pull_en_three)
    `CHK("slew", 2'b10, {pad.external_memory_interface_slow, pad.clock_out_pin_slow})
    $display("test pulls_slew done");
    for (int m = 0; m < 8; m++) begin
      v = 16'(xs());
      prst_base = prst_n;
      wr(`PMX_IDX_BUS_SEL, {1'b0, m[2:0], m[1:0], 4'h0, v[5:0]});
      repeat (4) @(posedge i_clk);
      for (int p = 0; p < `PMX_PP_PINS; p++) begin
        `CHK("pp_func", ppx(m, p), ppf[p])
      end
      for (int p = 0; p < 6; p++) begin
        `CHK("sp1_func", spx(m % 4, p), spf[p])
      end
      `CHK("addr_gpio", v[5:0], ag)
      // Consecutive modes always differ on some pin, so each remux costs one reset
      if (m > 0) `CHK("periph_reset", 1, prst_n - prst_base)
      rd(`PMX_IDX_STATUS, {13'h0000, m[1:0] == 2'b11, m == 7, 1'b0});
    end
    $display("test mux_modes done");
    drop <= 1'b1;
    repeat (6) @(posedge i_clk);
    `CHK("pull_off", 48'h0, {pad.pull_en_one, pad.pull_en_two, pad.pull_en_three})
    `CHK("bus_hold", 1'b1, pad.bus_hold_en)
    rd(`PMX_IDX_STATUS, 16'h0007);
    drop <= 1'b0;
    repeat (6) @(posedge i_clk);
    `CHK("pull_back", 16'hFF00, pad.pull_en_two)
    `CHK("bus_hold", 1'b0, pad.bus_hold_en)
    $display("test core_off done");
    rst(2);
    rd(`PMX_IDX_BUS_SEL, 16'h0000);
    `CHK("addr_gpio", 6'h00, ag)
    `CHK("pull_two", 16'hFFFF, pad.pull_en_two)
    `CHK("slew", 2'b00, {pad.external_memory_interface_slow, pad.clock_out_pin_slow})
    `CHK("pp_func0", pmx_pkg::PMX_FN_LCD, ppf[0])
    repeat (3) @(posedge i_clk);
    $display("test second_reset done");
    final_report();
  end
endmodule
